// ===== design/emi_defines.svh
`ifndef EMI_DEFINES_SVH
`define EMI_DEFINES_SVH
// Function
// - Drive a 24-bit address covering 16M words of each static bank.
// - SDRAM internal bank number always sits on address bits 14 and 13.
// - Address bit 10 high with the SDRAM read/write command requests auto precharge.
// - Static banks 8, 16 or 32 bits wide; SDRAM banks 16 or 32 only.
// - Two separate active-low SDRAM chip selects, one per SDRAM bank.
// - One row and one column strobe shared, qualified by the chip select.
// - Clock-enable output tells the SDRAM whether to sample its clock.
// - Shared write strobe: SDRAM write enable, and 16-bit static banks only.
// - Wait input low stretches a static access past its programmed count.
// - Eight active-low chip selects, one per static or external I/O bank.
// - Bank 0 width from straps: 01 byte, 10 half, 11 word, 00 reserved.
// - Output enable asserted low during every static read access.
// - Four active-low byte-lane write enables strobe only written lanes.
// - Same four lanes act as SDRAM data masks, masking unused lanes.

// ----------------------------------------
// Pin layout
// ----------------------------------------
`define EMI_ADDR_W 24
`define EMI_DATA_W 32
`define EMI_STATIC_BANKS 8
`define EMI_SDRAM_BANKS 2
`define EMI_AP_BIT 10
`define EMI_SD_BA_LO 13
`define EMI_SD_COL_W 10
`define EMI_SD_ROW_W 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EMI_RST_PINS_N 1'b1
`define EMI_RST_CKE 1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define EMI_CLK_KHZ 40000
`define EMI_TRCD_NS 20
`define EMI_TRCD_CYC (((`EMI_TRCD_NS * `EMI_CLK_KHZ) + 999999) / 1000000)
`define EMI_CAS_LAT_CYC 2
`endif

// ===== design/emi_pkg.sv
package emi_pkg;
  // Bus width codes, same coding as the boot straps
  typedef enum logic [1:0] {
    EMI_W_RSVD = 2'h0,
    EMI_W_BYTE = 2'h1,
    EMI_W_HALF = 2'h2,
    EMI_W_WORD = 2'h3
  } emi_width_e;

  typedef enum logic [2:0] {
    EMI_IDLE = 3'h0,
    EMI_ST_ACC = 3'h1,
    EMI_SD_ACT = 3'h2,
    EMI_SD_CMD = 3'h6,
    EMI_SD_LAT = 3'h4
  } emi_fsm_e;

  typedef struct packed {
    emi_fsm_e state;
    logic [7:0] cnt;
    logic write;
    logic sdram;
    emi_width_e boot_width;
    logic [31:0] wdata;
    logic [23:0] addr;
    logic [9:0] col;
    logic [31:0] data_out;
    logic data_oe_n;
    logic [1:0] sd_cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [7:0] rcs_n;
    logic oe_n;
    logic [3:0] lane_n;
    logic [31:0] rdata;
    logic rsp_valid;
  } emi_state_s;
endpackage

// ===== design/emi_lane_ctrl.sv
`include "emi_defines.svh"

module emi_lane_ctrl
(
  input wire emi_pkg::emi_width_e width,
  input wire logic [3:0] byte_en,
  input wire logic sdram,
  input wire logic write,
  output logic [3:0] lane_n,
  output logic we16_n
);
  import emi_pkg::*;

  logic [3:0] width_mask;

  always_comb
  begin
    unique case (width)
      EMI_W_BYTE: width_mask = 4'h1;
      EMI_W_HALF: width_mask = 4'h3;
      default: width_mask = 4'hF;
    endcase
    // Lanes outside the bank width never strobe, so stray enables are harmless
    if (sdram)
      lane_n = ~(byte_en & width_mask);
    else if (write)
      lane_n = ~(byte_en & width_mask);
    else
      lane_n = 4'hF;
    we16_n = !(write && !sdram && (width == EMI_W_HALF));
  end
endmodule

// ===== design/emi_pin_ctrl.sv
`include "emi_defines.svh"

module emi_pin_ctrl #(
  parameter int WAIT_W = 4,
  parameter int CAS_LAT = `EMI_CAS_LAT_CYC,
  parameter int TRCD = `EMI_TRCD_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_sdram,
  input wire logic [2:0] req_bank,
  input wire logic [`EMI_ADDR_W-1:0] req_addr,
  input wire logic [`EMI_DATA_W-1:0] req_wdata,
  input wire logic [3:0] req_byte_en,
  input wire logic [WAIT_W-1:0] req_wait_cycles,
  input wire logic [15:0] bank_width_cfg,
  input wire logic sdram_width_32,
  input wire logic sdram_clk_hold,
  output logic rsp_valid,
  output logic [`EMI_DATA_W-1:0] rsp_rdata,
  input wire logic [1:0] boot_bank_width,
  output logic boot_width_reserved,
  output logic [`EMI_ADDR_W-1:0] ext_addr,
  input wire logic [`EMI_DATA_W-1:0] ext_data_bus_in,
  output logic [`EMI_DATA_W-1:0] ext_data_bus_out,
  output logic ext_data_bus_oe_n,
  output logic [`EMI_SDRAM_BANKS-1:0] sdram_chip_sel_n,
  output logic sdram_row_strobe_n,
  output logic sdram_col_strobe_n,
  output logic sdram_clk_en,
  output logic shared_write_strobe_n,
  input wire logic ext_wait_n,
  output logic [`EMI_STATIC_BANKS-1:0] static_bank_sel_n,
  output logic read_output_enable_n,
  output logic [3:0] byte_lane_write_n
);
  import emi_pkg::*;

  emi_state_s r;
  emi_state_s next_r;
  emi_width_e req_width;
  emi_width_e lane_width;
  logic [3:0] lane_n;
  logic we16_n;
  logic [1:0] req_ibank;
  logic [`EMI_ADDR_W-1:0] row_addr;
  logic [`EMI_ADDR_W-1:0] col_addr;
  logic [`EMI_STATIC_BANKS-1:0] static_sel_n;
  logic [`EMI_SDRAM_BANKS-1:0] sdram_sel_n;
  logic cke_want;
  logic static_done;
  emi_state_s parked;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  always_comb
  begin
    if (req_bank == 3'h0)
      req_width = r.boot_width;
    else
      req_width = emi_width_e'(bank_width_cfg[{req_bank, 1'b0} +: 2]);
    // Reserved codes fall back to word so the bank is at least reachable
    if (req_width == EMI_W_RSVD)
      req_width = EMI_W_WORD;
    // SDRAM never runs 8 bits wide
    lane_width = req_sdram ? (sdram_width_32 ? EMI_W_WORD : EMI_W_HALF) : req_width;
  end

  // ----------------------------------------
  // Address split
  // ----------------------------------------
  // SDRAM address split: column [9:0], internal bank [11:10], row [23:12]
  always_comb
  begin
    req_ibank = req_addr[`EMI_SD_COL_W +: 2];
    row_addr = '0;
    row_addr[`EMI_SD_ROW_W-1:0] = req_addr[`EMI_ADDR_W-1 -: `EMI_SD_ROW_W];
    row_addr[`EMI_SD_BA_LO +: 2] = req_ibank;
    col_addr = '0;
    col_addr[`EMI_SD_COL_W-1:0] = r.col;
    col_addr[`EMI_SD_BA_LO +: 2] = r.addr[`EMI_SD_BA_LO +: 2];
    col_addr[`EMI_AP_BIT] = 1'b1;
  end

  emi_lane_ctrl u_lane
  (
    .width(lane_width),
    .byte_en(req_byte_en),
    .sdram(req_sdram),
    .write(req_write),
    .lane_n(lane_n),
    .we16_n(we16_n)
  );

  // A powered-down SDRAM needs one cycle with CKE high before a command
  assign req_ready = (r.state == EMI_IDLE) && (!req_sdram || r.cke);

  // ----------------------------------------
  // Bank selects
  // ----------------------------------------
  // Only bit 0 of the bank picks between the two SDRAM selects
  always_comb
  begin
    static_sel_n = ~(8'h1 << req_bank);
    sdram_sel_n = ~(2'h1 << req_bank[0]);
  end

  // ----------------------------------------
  // SDRAM clock enable
  // ----------------------------------------
  // CKE only drops while idle; an access in flight keeps the level it started with
  always_comb
  begin
    if (r.state != EMI_IDLE)
      cke_want = r.cke;
    else
      cke_want = !sdram_clk_hold || (req_valid && req_sdram);
  end

  // Programmed count spent and the device no longer holding the access off
  assign static_done = (r.cnt == 8'h0) && ext_wait_n;

  // ----------------------------------------
  // Parked pins
  // ----------------------------------------
  // Every idle cycle and the illegal-code branch start from this copy, so no strobe stays low while idle
  always_comb
  begin
    parked = r;
    parked.state = EMI_IDLE;
    parked.cnt = 8'h0;
    parked.rsp_valid = 1'b0;
    parked.data_oe_n = 1'b1;
    parked.sd_cs_n = {`EMI_SDRAM_BANKS{`EMI_RST_PINS_N}};
    parked.ras_n = `EMI_RST_PINS_N;
    parked.cas_n = `EMI_RST_PINS_N;
    parked.we_n = `EMI_RST_PINS_N;
    parked.rcs_n = {`EMI_STATIC_BANKS{`EMI_RST_PINS_N}};
    parked.oe_n = `EMI_RST_PINS_N;
    parked.lane_n = {4{`EMI_RST_PINS_N}};
    parked.cke = cke_want;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    unique case (r.state)
      EMI_IDLE:
      begin
        // Nothing taken this cycle leaves every pin parked
        next_r = parked;
        if (req_valid && req_ready)
        begin
          next_r.write = req_write;
          next_r.sdram = req_sdram;
          next_r.wdata = req_wdata;
          next_r.lane_n = lane_n;
          if (req_sdram)
          begin
            // Activate: row strobe with this bank's select
            next_r.state = EMI_SD_ACT;
            next_r.addr = row_addr;
            next_r.sd_cs_n = sdram_sel_n;
            next_r.ras_n = 1'b0;
            next_r.cnt = 8'(TRCD - 1);
            // Column waits in its own field; the pins carry the row until the command
            next_r.col = req_addr[`EMI_SD_COL_W-1:0];
          end
          else
          begin
            next_r.state = EMI_ST_ACC;
            next_r.addr = req_addr;
            next_r.rcs_n = static_sel_n;
            next_r.oe_n = req_write;
            next_r.we_n = we16_n;
            next_r.data_out = req_wdata;
            next_r.data_oe_n = !req_write;
            next_r.cnt = 8'(req_wait_cycles);
          end
        end
      end
      EMI_ST_ACC:
      begin
        // Count the programmed cycles first, then honour the wait input
        if (r.cnt != 8'h0)
          next_r.cnt = r.cnt - 8'h1;
        else if (static_done)
        begin
          next_r.state = EMI_IDLE;
          next_r.rsp_valid = 1'b1;
          if (!r.write)
            next_r.rdata = ext_data_bus_in;
          next_r.rcs_n = {`EMI_STATIC_BANKS{`EMI_RST_PINS_N}};
          next_r.oe_n = `EMI_RST_PINS_N;
          next_r.we_n = `EMI_RST_PINS_N;
          next_r.lane_n = {4{`EMI_RST_PINS_N}};
          next_r.data_oe_n = 1'b1;
        end
      end
      EMI_SD_ACT:
      begin
        // NOP while the row opens; selects stay with the bank
        next_r.ras_n = 1'b1;
        if (r.cnt != 8'h0)
          next_r.cnt = r.cnt - 8'h1;
        else
        begin
          next_r.state = EMI_SD_CMD;
          next_r.addr = col_addr;
          next_r.cas_n = 1'b0;
          next_r.we_n = !r.write;
          next_r.data_out = r.wdata;
          next_r.data_oe_n = !r.write;
          next_r.cnt = 8'(CAS_LAT - 1);
        end
      end
      EMI_SD_CMD:
      begin
        // Cycle after the command: NOP, bus released
        next_r.cas_n = 1'b1;
        next_r.we_n = 1'b1;
        next_r.sd_cs_n = {`EMI_SDRAM_BANKS{1'b1}};
        next_r.data_oe_n = 1'b1;
        if (r.write)
        begin
          // Auto precharge closes the row, so a write ends here
          next_r.state = EMI_IDLE;
          next_r.rsp_valid = 1'b1;
          next_r.lane_n = 4'hF;
        end
        else
          next_r.state = EMI_SD_LAT;
      end
      EMI_SD_LAT:
      begin
        // Wait out the CAS latency, then take the word
        if (r.cnt != 8'h0)
          next_r.cnt = r.cnt - 8'h1;
        else
        begin
          next_r.state = EMI_IDLE;
          next_r.rsp_valid = 1'b1;
          next_r.rdata = ext_data_bus_in;
          next_r.lane_n = 4'hF;
        end
      end
      default:
      begin
        // An illegal code parks the pins as well, not only the sequencer
        next_r = parked;
      end
    endcase
  end

  // Reset parks every pin and captures the strap again on each clock edge while reset is low
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.state <= EMI_IDLE;
      r.boot_width <= emi_width_e'(boot_bank_width);
      r.data_oe_n <= 1'b1;
      r.sd_cs_n <= {`EMI_SDRAM_BANKS{`EMI_RST_PINS_N}};
      r.ras_n <= `EMI_RST_PINS_N;
      r.cas_n <= `EMI_RST_PINS_N;
      r.we_n <= `EMI_RST_PINS_N;
      r.cke <= `EMI_RST_CKE;
      r.rcs_n <= {`EMI_STATIC_BANKS{`EMI_RST_PINS_N}};
      r.oe_n <= `EMI_RST_PINS_N;
      r.lane_n <= {4{`EMI_RST_PINS_N}};
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Every pin comes straight from a flip-flop, so no decode glitch reaches the board
  assign ext_addr = r.addr;
  assign ext_data_bus_out = r.data_out;
  assign ext_data_bus_oe_n = r.data_oe_n;
  assign sdram_chip_sel_n = r.sd_cs_n;
  assign sdram_row_strobe_n = r.ras_n;
  assign sdram_col_strobe_n = r.cas_n;
  assign sdram_clk_en = r.cke;
  assign shared_write_strobe_n = r.we_n;
  assign static_bank_sel_n = r.rcs_n;
  assign read_output_enable_n = r.oe_n;
  assign byte_lane_write_n = r.lane_n;

  // ----------------------------------------
  // Response
  // ----------------------------------------
  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rdata;
  assign boot_width_reserved = (r.boot_width == EMI_W_RSVD);
endmodule

// ===== tb/emi_pin_ctrl_chk.sv
module emi_pin_ctrl_chk
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic [23:0] ext_addr,
  input wire logic ext_data_bus_oe_n,
  input wire logic [1:0] sdram_chip_sel_n,
  input wire logic sdram_row_strobe_n,
  input wire logic sdram_col_strobe_n,
  input wire logic sdram_clk_en,
  input wire logic shared_write_strobe_n,
  input wire logic ext_wait_n,
  input wire logic [7:0] static_bank_sel_n,
  input wire logic read_output_enable_n,
  input wire logic [3:0] byte_lane_write_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic st_on;
  assign st_on = !(&static_bank_sel_n);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_pins: assert property (disable iff (1'b0) !rst_n |=> st_on == 1'b0 && !sdram_clk_en)
    else $error("pins not parked after reset");
  chk_idle_quiet: assert property (req_ready |-> !st_on && &sdram_chip_sel_n && &byte_lane_write_n)
    else $error("strobe active while idle");
  chk_one_bank: assert property ($onehot0({~static_bank_sel_n, ~sdram_chip_sel_n}))
    else $error("two selects at once");
  chk_read_oe: assert property (st_on && ext_data_bus_oe_n |-> !read_output_enable_n)
    else $error("static read without output enable");
  chk_no_contend: assert property (!read_output_enable_n |-> ext_data_bus_oe_n)
    else $error("data driven during read");
  chk_ap_bit: assert property (!sdram_col_strobe_n |-> ext_addr[10])
    else $error("column command without auto precharge");
  chk_cmd_qual: assert property (!sdram_row_strobe_n || !sdram_col_strobe_n |-> $onehot(~sdram_chip_sel_n) && sdram_clk_en)
    else $error("unqualified sdram command");
  chk_act_cas: assert property (!sdram_row_strobe_n |=> !sdram_col_strobe_n && $stable(ext_addr[14:13]))
    else $error("bank address moved after activate");
  chk_we_data: assert property (!shared_write_strobe_n |-> !ext_data_bus_oe_n)
    else $error("write strobe without data");
  chk_wait_hold: assert property (st_on && !ext_wait_n |=> st_on && $stable(static_bank_sel_n))
    else $error("access ended while wait low");
  cover property (st_on && !read_output_enable_n);
  cover property (!sdram_col_strobe_n && !shared_write_strobe_n);
  cover property (st_on && !ext_wait_n);
endmodule

bind emi_pin_ctrl emi_pin_ctrl_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .req_ready(req_ready),
  .ext_addr(ext_addr), .ext_data_bus_oe_n(ext_data_bus_oe_n), .sdram_chip_sel_n(sdram_chip_sel_n),
  .sdram_row_strobe_n(sdram_row_strobe_n), .sdram_col_strobe_n(sdram_col_strobe_n), .sdram_clk_en(sdram_clk_en),
  .shared_write_strobe_n(shared_write_strobe_n), .ext_wait_n(ext_wait_n), .static_bank_sel_n(static_bank_sel_n),
  .read_output_enable_n(read_output_enable_n), .byte_lane_write_n(byte_lane_write_n));

// ===== tb/emi_mem_model.sv
module emi_mem_model
(
  input wire logic core_clk,
  input wire logic [23:0] ext_addr,
  input wire logic [7:0] static_bank_sel_n,
  input wire logic read_output_enable_n,
  input wire logic sdram_col_strobe_n,
  input wire logic shared_write_strobe_n,
  input wire logic [3:0] stretch,
  output logic ext_wait_n,
  output logic [31:0] rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last = 32'h0;
  logic [1:0] pipe = 2'h0;
  logic [11:0] loc = 12'h0;
  logic [3:0] held = 4'h0;
  // Slow part pulls wait low for the first stretch cycles of its access
  assign ext_wait_n = (&static_bank_sel_n) || held >= stretch;
  // Released bus shows the inverse of the last value, never a stale copy
  assign rd = !read_output_enable_n ? {8'hC3, ext_addr} : pipe[1] ? {20'h5A5A0, loc} : ~last;
  always_ff @(posedge core_clk)
  begin
    last <= rd;
    held <= (&static_bank_sel_n) ? 4'h0 : held + 4'h1;
    pipe <= {pipe[0], !sdram_col_strobe_n && shared_write_strobe_n};
    if (!sdram_col_strobe_n)
      loc <= {ext_addr[14:13], ext_addr[9:0]};
  end
endmodule

// ===== tb/test_external_memory_pin_interface.sv
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module test_external_memory_pin_interface;
  timeunit 1ns;
  timeprecision 1ps;
  import emi_pkg::*;
  typedef struct packed {
    logic w;
    logic sd;
    logic [2:0] bank;
    logic [23:0] addr;
    logic [3:0] be, wc, lanes;
    logic we;
    logic [3:0] lat;
  } emi_row_s;
  logic core_clk, rst_n, req_valid, req_ready, req_write, req_sdram, sdram_clk_hold, rsp_valid;
  logic boot_width_reserved, ext_data_bus_oe_n, ras_n, cas_n, cke, we_n, ext_wait_n, oe_n, sd_w32;
  logic [2:0] req_bank;
  logic [23:0] req_addr, ext_addr;
  logic [31:0] rsp_rdata, bus_in, bus_out, mem_rd;
  logic [3:0] req_byte_en, req_wait_cycles, lane_n, stretch;
  logic [1:0] boot_bank_width, sd_cs_n;
  logic [7:0] rcs_n;
  int mismatches = 0;
  int n_tests = 0;
  emi_row_s rows [6] = '{'{0, 0, 5, 24'h012345, 4'hF, 0, 4'hF, 1, 2}, '{1, 0, 1, 24'h000444, 4'hF, 0, 4'hE, 1, 2},
    '{1, 0, 2, 24'h100002, 4'h2, 0, 4'hD, 0, 2}, '{1, 0, 7, 24'hFFFFFF, 4'h9, 2, 4'h6, 1, 4},
    '{1, 1, 1, 24'h000955, 4'h3, 0, 4'hC, 0, 3}, '{0, 1, 0, 24'hABC7FF, 4'hF, 0, 4'h0, 1, 5}};
  assign bus_in = ext_data_bus_oe_n ? mem_rd : bus_out;
  emi_pin_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_sdram(req_sdram), .req_bank(req_bank), .req_addr(req_addr),
    .req_wdata(32'hA1B2C3D4), .req_byte_en(req_byte_en), .req_wait_cycles(req_wait_cycles),
    .bank_width_cfg(16'hFFE4), .sdram_width_32(sd_w32), .sdram_clk_hold(sdram_clk_hold), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .boot_bank_width(boot_bank_width), .boot_width_reserved(boot_width_reserved),
    .ext_addr(ext_addr), .ext_data_bus_in(bus_in), .ext_data_bus_out(bus_out),
    .ext_data_bus_oe_n(ext_data_bus_oe_n), .sdram_chip_sel_n(sd_cs_n), .sdram_row_strobe_n(ras_n),
    .sdram_col_strobe_n(cas_n), .sdram_clk_en(cke), .shared_write_strobe_n(we_n), .ext_wait_n(ext_wait_n),
    .static_bank_sel_n(rcs_n), .read_output_enable_n(oe_n), .byte_lane_write_n(lane_n));
  emi_mem_model u_mem (.core_clk(core_clk), .ext_addr(ext_addr), .static_bank_sel_n(rcs_n),
    .read_output_enable_n(oe_n), .sdram_col_strobe_n(cas_n), .shared_write_strobe_n(we_n),
    .stretch(stretch), .ext_wait_n(ext_wait_n), .rd(mem_rd));
  always #12.5 core_clk = ~core_clk;

  // ----------------------------------------
  // One access, pins checked at the cycle that carries the command
  // ----------------------------------------
  task automatic run(input emi_row_s r);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge core_clk);
    req_write <= r.w;
    req_sdram <= r.sd;
    req_bank <= r.bank;
    req_addr <= r.addr;
    req_byte_en <= r.be;
    req_wait_cycles <= r.wc;
    req_valid <= 1'b1;
    do @(negedge core_clk); while (!req_ready && ++n < 20);
    if (!req_ready)
    begin
      mismatches++;
      print_verdict();
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    while (!rsp_valid && n < 40)
    begin
      @(negedge core_clk);
      n++;
      if (!ras_n)
        `CHK(ext_addr, {9'h0, r.addr[11:10], 1'b0, r.addr[23:12]})
      if (!seen && (!(&rcs_n) || !cas_n))
      begin
        seen = 1'b1;
        `CHK(lane_n, r.lanes)
        `CHK(we_n, r.we)
        `CHK(oe_n, r.w | r.sd)
        `CHK(ext_data_bus_oe_n, !r.w)
        `CHK(r.w ? bus_out : 32'h0, r.w ? 32'hA1B2C3D4 : 32'h0)
        `CHK(rcs_n, r.sd ? 8'hFF : ~(8'h01 << r.bank))
        `CHK(sd_cs_n, r.sd ? ~(2'h1 << r.bank[0]) : 2'h3)
        `CHK(ext_addr & (r.sd ? 24'h0067FF : 24'hFFFFFF), r.sd ? {9'h0, r.addr[11:10], 3'h1, r.addr[9:0]} : r.addr)
      end
    end
    if (!rsp_valid)
    begin
      mismatches++;
      print_verdict();
    end
    `CHK(seen, 1'b1)
    `CHK(4'(n), r.lat)
    if (!r.w)
      `CHK(rsp_rdata, r.sd ? {20'h5A5A0, r.addr[11:0]} : {8'hC3, r.addr})
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    {req_write, req_sdram, req_bank, req_addr, req_byte_en, req_wait_cycles} = '0;
    boot_bank_width = 2'h0;
    sdram_clk_hold = 1'b1;
    sd_w32 = 1'b1;
    stretch = 4'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK(boot_width_reserved, 1'b1)
    `CHK(cke, 1'b0)
    @(posedge core_clk);
    sdram_clk_hold <= 1'b0;
    foreach (rows[i])
      run(rows[i]);
    stretch <= 4'h3;
    run('{0, 0, 3, 24'h000300, 4'hF, 0, 4'hF, 1, 5});
    stretch <= 4'h0;
    @(posedge core_clk);
    rst_n <= 1'b0;
    boot_bank_width <= 2'h2;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK(boot_width_reserved, 1'b0)
    run('{1, 0, 0, 24'h000010, 4'hF, 0, 4'hC, 0, 2});
    @(posedge core_clk);
    sd_w32 <= 1'b0;
    sdram_clk_hold <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK(cke, 1'b0)
    run('{1, 1, 0, 24'h000010, 4'hF, 0, 4'hC, 0, 3});
    print_verdict();
  end
endmodule
